/* File: common/pcmbx_pkg.sv */
// Package with register map, field positions and carrier types of the config/mailbox block
package pcmbx_pkg;
  localparam logic [31:0] OFS_CFG_DATA   = 32'h0f000c14;
  localparam logic [31:0] OFS_CFG_ADDR   = 32'h0f000c18;
  localparam logic [31:0] OFS_MAILBOX    = 32'h0f000c1c;
  localparam logic [31:0] OFS_INT_CTRL   = 32'h0f000c28;
  localparam logic [31:0] RST_WORD       = 32'h00000000;
  localparam int          FLAG_CLR_BIT   = 28;
  localparam int          FLAG_STAT_BIT  = 4;
  localparam int          MBAR_LSB       = 11;
  localparam int          MBAR_W         = 21;
  localparam logic [MBAR_W-1:0] MBAR_RST = 21'h000000;
  localparam logic [31:0] CFG_ADDR_RO_MASK = 32'h00000002;

  // CPU internal-bus register access
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pcmbx_cpu_req_s;

  // PCI target memory access
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pcmbx_pci_req_s;

  typedef enum logic [1:0] {
    PCMBX_IDLE = 2'b00,
    PCMBX_ADDR = 2'b01,
    PCMBX_DATA = 2'b11
  } pcmbx_cfg_state_e;
endpackage

/* File: hdl/pcmbx_cfg_seq.sv */
// Configuration cycle sequencer: address phase then data phase
`timescale 1ns/1ps
module pcmbx_cfg_seq (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        start_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] cfg_addr_in,
  input  wire logic [31:0] cfg_data_in,
  input  wire logic        done_in,
  input  wire logic [31:0] rd_data_in,
  output logic             busy_out,
  output logic             ad_oe_out,
  output logic [31:0]      ad_out,
  output logic             addr_phase_out,
  output logic             rd_load_out,
  output logic [31:0]      rd_word_out
);
  pcmbx_pkg::pcmbx_cfg_state_e state_q;
  logic                        wr_q;

  // Phase sequencing
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= pcmbx_pkg::PCMBX_IDLE;
      wr_q    <= 1'b0;
    end else begin
      unique case (state_q)
        pcmbx_pkg::PCMBX_IDLE: begin
          if (start_in) begin
            state_q <= pcmbx_pkg::PCMBX_ADDR;
            wr_q    <= wr_in;
          end
        end
        pcmbx_pkg::PCMBX_ADDR: state_q <= pcmbx_pkg::PCMBX_DATA;
        pcmbx_pkg::PCMBX_DATA: begin
          if (done_in) begin
            state_q <= pcmbx_pkg::PCMBX_IDLE;
          end
        end
        default: state_q <= pcmbx_pkg::PCMBX_IDLE;
      endcase
    end
  end

  // Registered pin outputs; address word goes out whole in the address phase
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ad_out         <= pcmbx_pkg::RST_WORD;
      ad_oe_out      <= 1'b0;
      addr_phase_out <= 1'b0;
      busy_out       <= 1'b0;
      rd_load_out    <= 1'b0;
      rd_word_out    <= pcmbx_pkg::RST_WORD;
    end else begin
      busy_out       <= (state_q != pcmbx_pkg::PCMBX_IDLE) || start_in;
      addr_phase_out <= (state_q == pcmbx_pkg::PCMBX_IDLE) && start_in;
      rd_load_out    <= 1'b0;
      if ((state_q == pcmbx_pkg::PCMBX_IDLE) && start_in) begin
        ad_out    <= cfg_addr_in;
        ad_oe_out <= 1'b1;
      end else if (state_q == pcmbx_pkg::PCMBX_ADDR) begin
        ad_out    <= wr_q ? cfg_data_in : pcmbx_pkg::RST_WORD;
        ad_oe_out <= wr_q;
      end else if ((state_q == pcmbx_pkg::PCMBX_DATA) && done_in) begin
        ad_oe_out <= 1'b0;
        if (!wr_q) begin
          rd_load_out <= 1'b1;
          rd_word_out <= rd_data_in;
        end
      end
    end
  end
endmodule

/* File: hdl/pcmbx_top.sv */
// Register slice of the PCI host unit: config data/address, mailbox and its access flag
`timescale 1ns/1ps
// Overview of operation
// - 32-bit read/write configuration data register
// - Address register driven on AD in address phase
// - Mailbox read/write from CPU and PCI
// - Mailbox decoded in I/O and PCI memory
// - PCI mailbox access sets flag; CPU does not
// - PCI mailbox address from configuration header base
// - Compare PCI address bits 31 to 11 only
// - Writing one to bit 28 clears flag
module pcmbx_top (
  input  wire logic                      clk_sys_in,
  input  wire logic                      nrst_in,
  input  wire pcmbx_pkg::pcmbx_cpu_req_s cpu_in,
  input  wire logic                      cfg_start_in,
  input  wire logic                      cfg_wr_in,
  input  wire logic                      cfg_done_in,
  input  wire logic [31:0]               cfg_rd_data_in,
  input  wire pcmbx_pkg::pcmbx_pci_req_s pci_in,
  input  wire logic                      mbar_wr_in,
  input  wire logic [31:0]               mbar_wdata_in,
  output logic [31:0]                    cpu_rdata_out,
  output logic                           cpu_ack_out,
  output logic [31:0]                    pci_rdata_out,
  output logic                           pci_hit_out,
  output logic [31:0]                    mbar_rdata_out,
  output logic                           mail_access_flag_out,
  output logic                           cfg_busy_out,
  output logic [31:0]                    ad_out,
  output logic                           ad_oe_out,
  output logic                           addr_phase_out
);
  // Programmer-visible state
  logic [31:0]                     config_data_word_q;
  logic [31:0]                     config_address_word_q;
  logic [31:0]                     mailbox_message_word_q;
  logic [pcmbx_pkg::MBAR_W-1:0]    mailbox_base_address_cfg_q;
  logic                            mail_access_flag_q;
  // Decode, strobes and links to the sequencer
  logic                            cpu_data_sel;
  logic                            cpu_addr_sel;
  logic                            cpu_mail_sel;
  logic                            cpu_ctrl_sel;
  logic                            pci_mail_hit;
  logic                            rd_load;
  logic [31:0]                     rd_word;
  logic                            seq_busy;
  logic                            seq_start;
  logic                            pci_base_match;
  logic                            cpu_data_wr;
  logic                            cpu_addr_wr;
  logic                            cpu_mail_wr;
  logic                            cpu_flag_clr;
  logic                            pci_mail_wr;
  logic [31:0]                     cpu_rd_mux;

  // Internal I/O space decode of the CPU bus
  assign cpu_data_sel = cpu_in.req && (cpu_in.addr == pcmbx_pkg::OFS_CFG_DATA);
  assign cpu_addr_sel = cpu_in.req && (cpu_in.addr == pcmbx_pkg::OFS_CFG_ADDR);
  assign cpu_mail_sel = cpu_in.req && (cpu_in.addr == pcmbx_pkg::OFS_MAILBOX);
  assign cpu_ctrl_sel = cpu_in.req && (cpu_in.addr == pcmbx_pkg::OFS_INT_CTRL);

  // PCI memory decode against the header base, upper 21 bits only
  assign pci_base_match = (pci_in.addr[31:pcmbx_pkg::MBAR_LSB] ==
                           mailbox_base_address_cfg_q);
  assign pci_mail_hit   = pci_in.req && pci_base_match;

  // Write strobes; the address register refuses writes while a cycle runs
  assign cpu_data_wr    = cpu_data_sel && cpu_in.wr;
  assign cpu_addr_wr    = cpu_addr_sel && cpu_in.wr && !seq_busy;
  assign cpu_mail_wr    = cpu_mail_sel && cpu_in.wr;
  assign pci_mail_wr    = pci_mail_hit && pci_in.wr;

  // Write-one clear of the access flag; a zero in that bit does nothing
  assign cpu_flag_clr   = cpu_ctrl_sel && cpu_in.wr &&
                          cpu_in.wdata[pcmbx_pkg::FLAG_CLR_BIT];

  // A start is taken only while the sequencer is idle
  assign seq_start      = cfg_start_in && !seq_busy;

  // Mailbox base held in the configuration header
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mailbox_base_address_cfg_q <= pcmbx_pkg::MBAR_RST;
    end else if (mbar_wr_in) begin
      mailbox_base_address_cfg_q <= mbar_wdata_in[31:pcmbx_pkg::MBAR_LSB];
    end
  end

  // Configuration data register, loaded by CPU or by a finished read cycle
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      config_data_word_q <= pcmbx_pkg::RST_WORD;
    end else if (rd_load) begin
      config_data_word_q <= rd_word;
    end else if (cpu_data_wr) begin
      config_data_word_q <= cpu_in.wdata;
    end
  end

  // Configuration address register; bit 1 is read-only and stays zero
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      config_address_word_q <= pcmbx_pkg::RST_WORD;
    end else if (cpu_addr_wr) begin
      config_address_word_q <= cpu_in.wdata & ~pcmbx_pkg::CFG_ADDR_RO_MASK;
    end
  end

  // Mailbox word; a PCI write takes priority over a CPU write in the same cycle
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mailbox_message_word_q <= pcmbx_pkg::RST_WORD;
    end else if (pci_mail_wr) begin
      mailbox_message_word_q <= pci_in.wdata;
    end else if (cpu_mail_wr) begin
      mailbox_message_word_q <= cpu_in.wdata;
    end
  end

  // Access flag: PCI access sets, write-one clears, set wins
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mail_access_flag_q <= 1'b0;
    end else if (pci_mail_hit) begin
      mail_access_flag_q <= 1'b1;
    end else if (cpu_flag_clr) begin
      mail_access_flag_q <= 1'b0;
    end
  end

  // CPU read-back mux; unmapped addresses read zero
  always_comb begin
    cpu_rd_mux = pcmbx_pkg::RST_WORD;
    if (cpu_data_sel) begin
      cpu_rd_mux = config_data_word_q;
    end else if (cpu_addr_sel) begin
      cpu_rd_mux = config_address_word_q;
    end else if (cpu_mail_sel) begin
      cpu_rd_mux = mailbox_message_word_q;
    end else if (cpu_ctrl_sel) begin
      cpu_rd_mux[pcmbx_pkg::FLAG_STAT_BIT] = mail_access_flag_q;
    end
  end

  // Acknowledge every CPU access one cycle later, mapped or not
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_ack_out <= 1'b0;
    end else begin
      cpu_ack_out <= cpu_in.req;
    end
  end

  // Read data registered so that it stands beside the acknowledge
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_rdata_out <= pcmbx_pkg::RST_WORD;
    end else begin
      cpu_rdata_out <= cpu_rd_mux;
    end
  end

  // Mailbox hit pulse toward the PCI side
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pci_hit_out <= 1'b0;
    end else begin
      pci_hit_out <= pci_mail_hit;
    end
  end

  // PCI read data: the mailbox as it stood before any same-cycle write
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pci_rdata_out <= pcmbx_pkg::RST_WORD;
    end else begin
      pci_rdata_out <= pci_mail_hit ? mailbox_message_word_q : pcmbx_pkg::RST_WORD;
    end
  end

  // Header view of the mailbox base; the undecoded low bits read zero
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mbar_rdata_out <= pcmbx_pkg::RST_WORD;
    end else begin
      mbar_rdata_out <= {mailbox_base_address_cfg_q,
                         pcmbx_pkg::RST_WORD[pcmbx_pkg::MBAR_LSB-1:0]};
    end
  end

  // Flag as the interrupt logic sees it
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mail_access_flag_out <= 1'b0;
    end else begin
      mail_access_flag_out <= mail_access_flag_q;
    end
  end

  // Configuration cycle engine
  pcmbx_cfg_seq u_seq (
    .clk_sys_in     (clk_sys_in),
    .nrst_in        (nrst_in),
    .start_in       (seq_start),
    .wr_in          (cfg_wr_in),
    .cfg_addr_in    (config_address_word_q),
    .cfg_data_in    (config_data_word_q),
    .done_in        (cfg_done_in),
    .rd_data_in     (cfg_rd_data_in),
    .busy_out       (seq_busy),
    .ad_oe_out      (ad_oe_out),
    .ad_out         (ad_out),
    .addr_phase_out (addr_phase_out),
    .rd_load_out    (rd_load),
    .rd_word_out    (rd_word)
  );

  // Busy comes straight from the sequencer's register
  assign cfg_busy_out = seq_busy;
endmodule

/* File: tb/pcmbx_properties.sv */
// Assertion checker for the config/mailbox register slice, bound to the top module
`timescale 1ns/1ps
module pcmbx_checker (
  input wire logic                      clk_sys_in,
  input wire logic                      nrst_in,
  input wire pcmbx_pkg::pcmbx_cpu_req_s cpu_in,
  input wire pcmbx_pkg::pcmbx_pci_req_s pci_in,
  input wire logic                      cfg_start_in,
  input wire logic [31:0]               mbar_rdata_out,
  input wire logic                      cpu_ack_out,
  input wire logic                      pci_hit_out,
  input wire logic                      mail_access_flag_out,
  input wire logic                      cfg_busy_out,
  input wire logic [31:0]               ad_out,
  input wire logic                      ad_oe_out,
  input wire logic                      addr_phase_out
);
  logic [31:0] addr_copy_q;
  logic        hit_now;
  logic        ctl_wr;
  // Mailbox match on the upper 21 address bits, and control-register write
  assign hit_now = pci_in.req && pci_in.addr[31:11] == mbar_rdata_out[31:11];
  assign ctl_wr = cpu_in.req && cpu_in.wr && cpu_in.addr == pcmbx_pkg::OFS_INT_CTRL;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // Copy of the address register as the CPU last wrote it while idle
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in)
      addr_copy_q <= 32'h00000000;
    else if (cpu_in.req && cpu_in.wr && cpu_in.addr == pcmbx_pkg::OFS_CFG_ADDR && !cfg_busy_out)
      addr_copy_q <= cpu_in.wdata & ~pcmbx_pkg::CFG_ADDR_RO_MASK;
  end
  a_cpu_ack_given: assert property (cpu_in.req |=> cpu_ack_out)
    else $error("cpu access not acknowledged");
  a_cfg_phase_start: assert property (cfg_start_in && !cfg_busy_out
    |=> addr_phase_out && ad_oe_out)
    else $error("no address phase after start");
  a_ad_carries_addr: assert property (addr_phase_out
    |-> ad_oe_out && ad_out == addr_copy_q)
    else $error("address phase word wrong");
  a_pci_hit_match: assert property (hit_now |=> pci_hit_out)
    else $error("mailbox match not answered");
  a_pci_hit_miss: assert property (!hit_now |=> !pci_hit_out)
    else $error("mailbox hit without match");
  a_flag_after_hit: assert property (pci_hit_out |=> mail_access_flag_out)
    else $error("flag not set by pci access");
  a_flag_rise_src: assert property ($rose(mail_access_flag_out) |-> $past(pci_hit_out))
    else $error("flag set without pci access");
  a_flag_clear_one: assert property (ctl_wr && cpu_in.wdata[28] && !pci_in.req
    |-> ##2 !mail_access_flag_out)
    else $error("flag not cleared");
  a_flag_clear_zero: assert property (ctl_wr && !cpu_in.wdata[28] && mail_access_flag_out
    |=> mail_access_flag_out)
    else $error("flag lost on zero write");
  cover property (pci_hit_out ##1 mail_access_flag_out);
  cover property (addr_phase_out ##1 ad_oe_out);
  cover property ($fell(mail_access_flag_out));
endmodule
bind pcmbx_top pcmbx_checker i_checker (.clk_sys_in, .nrst_in, .cpu_in, .pci_in, .cfg_start_in,
  .mbar_rdata_out, .cpu_ack_out, .pci_hit_out, .mail_access_flag_out, .cfg_busy_out, .ad_out,
  .ad_oe_out, .addr_phase_out);

/* File: tb/pcmbx_far_model.sv */
// Far-side configuration target: keeps the address phase word and ends the data phase
`timescale 1ns/1ps
module pcmbx_far_model (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        addr_phase_in,
  input  wire logic [3:0]  wait_in,
  input  wire logic [31:0] ad_in,
  input  wire logic [31:0] reply_in,
  output logic             done_out,
  output logic [31:0]      data_out,
  output logic [31:0]      seen_addr_out,
  output logic [31:0]      seen_data_out
);
  logic [4:0] count_q;
  // Wait count after the address phase, then a one-cycle done with read data
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_q <= 5'h00;
      done_out <= 1'b0;
      data_out <= 32'h00000000;
      seen_addr_out <= 32'h00000000;
      seen_data_out <= 32'h00000000;
    end else begin
      done_out <= count_q == 5'h01;
      data_out <= (count_q == 5'h01) ? reply_in : ~data_out; // Toggles while not valid
      if (count_q == 5'h01) begin
        seen_data_out <= ad_in; // Data-phase word as it stands on AD
      end
      if (addr_phase_in) begin
        seen_addr_out <= ad_in;
        count_q <= {1'b0, wait_in} + 5'h01;
      end else if (count_q != 5'h00)
        count_q <= count_q - 5'h01;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the config/mailbox register slice
`timescale 1ns/1ps
module testbench;
  logic                      clk_sys_in = 1'b0;
  logic                      nrst_in = 1'b0;
  pcmbx_pkg::pcmbx_cpu_req_s cpu_in = '0;
  pcmbx_pkg::pcmbx_pci_req_s pci_in = '0;
  logic                      cfg_start_in = 1'b0, cfg_wr_in = 1'b0, mbar_wr_in = 1'b0;
  logic [31:0]               mbar_wdata_in = 32'h0, reply_word = 32'h0;
  logic [3:0]                wait_cycles = 4'h0;
  logic [31:0]               cfg_rd_data_in, cpu_rdata_out, pci_rdata_out, mbar_rdata_out;
  logic [31:0]               ad_out, seen_addr, seen_data;
  logic                      cfg_done_in, cpu_ack_out, pci_hit_out, mail_access_flag_out;
  logic                      cfg_busy_out, ad_oe_out, addr_phase_out;
  int                        bad_count = 0, comparisons = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  pcmbx_top i_dut (.clk_sys_in, .nrst_in, .cpu_in, .cfg_start_in, .cfg_wr_in, .cfg_done_in,
    .cfg_rd_data_in, .pci_in, .mbar_wr_in, .mbar_wdata_in, .cpu_rdata_out, .cpu_ack_out,
    .pci_rdata_out, .pci_hit_out, .mbar_rdata_out, .mail_access_flag_out, .cfg_busy_out,
    .ad_out, .ad_oe_out, .addr_phase_out);
  pcmbx_far_model i_far (.clk_sys_in, .nrst_in, .addr_phase_in(addr_phase_out),
    .wait_in(wait_cycles), .ad_in(ad_out), .reply_in(reply_word), .done_out(cfg_done_in),
    .data_out(cfg_rd_data_in), .seen_addr_out(seen_addr), .seen_data_out(seen_data));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // CPU access: request for one cycle, ack and read data one cycle later
  task automatic cpu(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk_sys_in) cpu_in <= '{1'b1, wr, a, d};
    @(negedge clk_sys_in) cpu_in.req <= 1'b0;
    chk({31'h0, cpu_ack_out}, 32'h1);
    if (!wr) chk(cpu_rdata_out, d);
  endtask
  // PCI target access to the mailbox window
  task automatic pci(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic h);
    @(negedge clk_sys_in) pci_in <= '{1'b1, wr, a, d};
    @(negedge clk_sys_in) pci_in.req <= 1'b0;
    chk({31'h0, pci_hit_out}, {31'h0, h});
    if (h && !wr) chk(pci_rdata_out, d);
  endtask
  // Configuration cycle with a chosen far-side delay
  task automatic cfg(input logic wr, input logic [31:0] rep, input logic [3:0] w);
    @(negedge clk_sys_in) cfg_start_in <= 1'b1;
    cfg_wr_in <= wr;
    reply_word <= rep;
    wait_cycles <= w;
    @(negedge clk_sys_in) cfg_start_in <= 1'b0;
    repeat (40) if (cfg_busy_out) @(negedge clk_sys_in);
    chk({31'h0, cfg_busy_out}, 32'h0);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    for (int i = 0; i < 3; i++) cpu(1'b0, pcmbx_pkg::OFS_CFG_DATA + 32'(4 * i), 32'h0);
    cpu(1'b1, pcmbx_pkg::OFS_CFG_DATA, 32'hcafe0001);
    cpu(1'b0, pcmbx_pkg::OFS_CFG_DATA, 32'hcafe0001);
    cpu(1'b1, pcmbx_pkg::OFS_CFG_ADDR, 32'hffffffff);
    cpu(1'b0, pcmbx_pkg::OFS_CFG_ADDR, 32'hfffffffd);
    cpu(1'b0, 32'h0f000c20, 32'h0);
    @(negedge clk_sys_in) mbar_wr_in <= 1'b1;
    mbar_wdata_in <= 32'h12345fff;
    @(negedge clk_sys_in) mbar_wr_in <= 1'b0;
    @(negedge clk_sys_in) chk(mbar_rdata_out, 32'h12345800);
    cpu(1'b1, pcmbx_pkg::OFS_MAILBOX, 32'ha5a5c3c3);
    chk({31'h0, mail_access_flag_out}, 32'h0);
    pci(1'b0, 32'h12345ffc, 32'ha5a5c3c3, 1'b1);
    @(negedge clk_sys_in) chk({31'h0, mail_access_flag_out}, 32'h1);
    pci(1'b1, 32'h12345804, 32'h600df00d, 1'b1);
    pci(1'b1, 32'h12346000, 32'h0, 1'b0);
    pci(1'b1, 32'h123457fc, 32'h0, 1'b0);
    cpu(1'b0, pcmbx_pkg::OFS_MAILBOX, 32'h600df00d);
    cpu(1'b1, pcmbx_pkg::OFS_INT_CTRL, 32'h0);
    @(negedge clk_sys_in) chk({31'h0, mail_access_flag_out}, 32'h1);
    cpu(1'b0, pcmbx_pkg::OFS_INT_CTRL, 32'h00000010);
    cpu(1'b1, pcmbx_pkg::OFS_INT_CTRL, 32'h10000000);
    @(negedge clk_sys_in) chk({31'h0, mail_access_flag_out}, 32'h0);
    cpu(1'b0, pcmbx_pkg::OFS_INT_CTRL, 32'h0);
    cpu(1'b1, pcmbx_pkg::OFS_CFG_ADDR, 32'h80000800);
    cfg(1'b1, 32'h0, 4'h0);
    chk(seen_addr, 32'h80000800);
    chk(seen_data, 32'hcafe0001);
    cfg(1'b0, 32'h0badbeef, 4'h5);
    cpu(1'b0, pcmbx_pkg::OFS_CFG_DATA, 32'h0badbeef);
    end_of_test;
  end
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    bad_count++;
    end_of_test;
  end
endmodule
